// file: inc/almf_regs.svh
// Register offsets, bit maps and reset values of the alarm block
`ifndef ALMF_REGS_SVH
`define ALMF_REGS_SVH
// ****************************************
// Offsets
// ****************************************
`define ALMF_OFS_FAULT_SEL 8'h09
`define ALMF_OFS_FORCE 8'h0C
`define ALMF_OFS_CLEAR 8'h0F
`define ALMF_OFS_STATUS 8'h30
`define ALMF_OFS_CRIT_SEL 8'h51
`define ALMF_OFS_LATCH 8'h54
// ****************************************
// Bit maps and reset values
// ****************************************
`define ALMF_STATUS_BITS 24'hEC0FFE
`define ALMF_LATCH_BITS 24'h6C0FF8
`define ALMF_ALWAYS_LATCH 24'h800004
`define ALMF_BIT_RELAY 2
`define ALMF_BIT_ZCROSS 1
`define ALMF_SEL_RESET 24'h000000
`define ALMF_LATCH_RESET 24'h000000
`endif

// file: inc/almf_pkg.sv
// Types shared by the alarm latch, mask and force block
package almf_pkg;
    typedef logic [23:0] almf_word_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        almf_word_t wdata;
    } almf_req_s;
    typedef struct packed {
        almf_word_t latch_cfg;
        almf_word_t fault_sel;
        almf_word_t crit_sel;
    } almf_nvm_s;
    typedef enum logic [1:0] {
        ALMF_IDLE,
        ALMF_SAVE,
        ALMF_LOAD
    } almf_nvm_e;
endpackage

// file: design/almf_flag_cell.sv
// One alarm status flag with set, host clear and interval clear
`timescale 1ns/100ps
module almf_flag_cell (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Control
    input wire logic set_in,
    input wire logic host_clr_in,
    input wire logic auto_clr_in,
    // State
    output logic flag_out
);
    logic flag_q;

    // Any set beats both clears so no event is lost
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_q <= 1'b0;
        end else if (set_in) begin
            flag_q <= 1'b1;
        end else if (host_clr_in || auto_clr_in) begin
            flag_q <= 1'b0;
        end
    end

    assign flag_out = flag_q;
endmodule

// file: design/almf_top.sv
// Alarm status flags with latch config, pin selects and forcing
//
// Contract
// - Latched alarm holds until host clear
// - Unlatched alarm clears at interval end
// - Latch config only on listed bits
// - Latch config storable to nonvolatile memory
// - First select register drives fault pin
// - Second select register drives critical pin
// - Select one enables alarm, zero ignores
// - Select bits follow status bit map
// - Selects reset zero, storable to memory
// - Force one sets matching flag
// - Force zero no effect, reads zero
// - Clear one clears flag, zero nothing
// - Status register read only, all flags
// - Zero crossing flag clears itself
`timescale 1ns/100ps
`include "almf_regs.svh"
module almf_top
    import almf_pkg::*;
#(
    parameter int WIDTH = 24
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    // Register port from the host interface
    input wire almf_req_s req_in,
    output almf_word_t rdata_out,
    output logic rvalid_out,
    // Alarm sources
    input wire logic [WIDTH-1:0] alarm_event_in,
    input wire logic interval_done_in,
    // Nonvolatile store
    input wire logic nvm_save_in,
    input wire logic nvm_load_in,
    input wire almf_nvm_s nvm_image_in,
    output almf_nvm_s nvm_image_out,
    output logic nvm_write_out,
    // Alarm pins and status
    output logic fault_alarm_pin_out,
    output logic critical_alarm_pin_out,
    output almf_word_t alarm_status_out
);
    // ****************************************
    // Decode
    // ****************************************
    function automatic logic hit(input almf_req_s r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    almf_word_t latch_cfg_q;
    almf_word_t fault_sel_q;
    almf_word_t crit_sel_q;
    almf_word_t flags;
    almf_word_t set_vec;
    almf_word_t host_clr;
    almf_word_t auto_clr;
    almf_word_t latched;
    almf_nvm_e nvm_state_q;
    logic fault_q;
    logic crit_q;

    // ****************************************
    // Configuration registers
    // ****************************************
    // latch config bits
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            latch_cfg_q <= `ALMF_LATCH_RESET;
        end else if (hit(req_in, `ALMF_OFS_LATCH)) begin
            latch_cfg_q <= req_in.wdata & `ALMF_LATCH_BITS;
        end else if (nvm_state_q == ALMF_LOAD) begin
            latch_cfg_q <= nvm_image_in.latch_cfg & `ALMF_LATCH_BITS;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fault_sel_q <= `ALMF_SEL_RESET;
            crit_sel_q <= `ALMF_SEL_RESET;
        end else begin
            if (hit(req_in, `ALMF_OFS_FAULT_SEL)) begin
                fault_sel_q <= req_in.wdata & `ALMF_STATUS_BITS;
            end else if (nvm_state_q == ALMF_LOAD) begin
                fault_sel_q <= nvm_image_in.fault_sel & `ALMF_STATUS_BITS;
            end
            if (hit(req_in, `ALMF_OFS_CRIT_SEL)) begin
                crit_sel_q <= req_in.wdata & `ALMF_STATUS_BITS;
            end else if (nvm_state_q == ALMF_LOAD) begin
                crit_sel_q <= nvm_image_in.crit_sel & `ALMF_STATUS_BITS;
            end
        end
    end

    // ****************************************
    // Nonvolatile save and load
    // ****************************************
    // Save takes priority; a load the same cycle is dropped
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nvm_state_q <= ALMF_IDLE;
        end else if (nvm_save_in) begin
            nvm_state_q <= ALMF_SAVE;
        end else if (nvm_load_in) begin
            nvm_state_q <= ALMF_LOAD;
        end else begin
            nvm_state_q <= ALMF_IDLE;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nvm_image_out <= '0;
            nvm_write_out <= 1'b0;
        end else begin
            nvm_write_out <= 1'b0;
            unique case (nvm_state_q)
                ALMF_SAVE: begin
                    nvm_image_out <= '{latch_cfg_q, fault_sel_q, crit_sel_q};
                    nvm_write_out <= 1'b1;
                end
                ALMF_IDLE, ALMF_LOAD: begin
                    nvm_write_out <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // Relay and data ready have no latch config and always hold,
    // so a forced relay state is not lost at interval end
    assign latched = latch_cfg_q | `ALMF_ALWAYS_LATCH;

    always_comb begin
        set_vec = alarm_event_in & `ALMF_STATUS_BITS;
        if (hit(req_in, `ALMF_OFS_FORCE)) begin
            set_vec = set_vec | (req_in.wdata & `ALMF_STATUS_BITS);
        end
        host_clr = '0;
        if (hit(req_in, `ALMF_OFS_CLEAR)) begin
            host_clr = req_in.wdata;
        end
        auto_clr = interval_done_in ? ~latched : '0;
    end

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_flag
            if (((`ALMF_STATUS_BITS >> gi) & 1) != 0) begin : g_used
                almf_flag_cell u_cell (
                    .clk_sys_in(clk_sys_in),
                    .rstn_in(rstn_in),
                    .set_in(set_vec[gi]),
                    .host_clr_in(host_clr[gi]),
                    .auto_clr_in(auto_clr[gi]),
                    .flag_out(flags[gi])
                );
            end else begin : g_none
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    assign alarm_status_out = flags;

    // ****************************************
    // Alarm pins
    // ****************************************
    // masked OR to pins
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            fault_q <= 1'b0;
            crit_q <= 1'b0;
        end else begin
            fault_q <= |(flags & fault_sel_q);
            crit_q <= |(flags & crit_sel_q);
        end
    end

    assign fault_alarm_pin_out = fault_q;
    assign critical_alarm_pin_out = crit_q;

    // ****************************************
    // Read path
    // ****************************************
    // Force and clear are write only; unmapped reads give zero
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_out <= '0;
            rvalid_out <= 1'b0;
        end else begin
            rvalid_out <= req_in.rd;
            if (req_in.rd) begin
                unique case (req_in.addr)
                    `ALMF_OFS_STATUS: rdata_out <= flags;
                    `ALMF_OFS_FAULT_SEL: rdata_out <= fault_sel_q;
                    `ALMF_OFS_CRIT_SEL: rdata_out <= crit_sel_q;
                    `ALMF_OFS_LATCH: rdata_out <= latch_cfg_q;
                    default: rdata_out <= '0;
                endcase
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    AST_LATCH_HOLD: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (flags[6] && latch_cfg_q[6] && !host_clr[6]) |=> flags[6])
        else $error("latched flag dropped without clear");

    AST_AUTO_CLEAR: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (interval_done_in && !latch_cfg_q[5] && !set_vec[5])
        |=> !flags[5])
        else $error("unlatched flag survived interval end");

    AST_LATCH_MAP: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (latch_cfg_q & ~`ALMF_LATCH_BITS) == 24'h000000)
        else $error("latch config holds unused bit");

    AST_NVM_SAVE: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (nvm_save_in && !hit(req_in, `ALMF_OFS_LATCH)) ##1 1'b1
        |=> nvm_write_out && nvm_image_out.latch_cfg == $past(latch_cfg_q))
        else $error("save did not capture latch config");

    AST_FAULT_PIN: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ##1 fault_alarm_pin_out == $past(|(flags & fault_sel_q)))
        else $error("fault pin disagrees with selection");

    AST_CRIT_PIN: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (crit_sel_q == 24'h000000) [*2] |-> !critical_alarm_pin_out)
        else $error("critical pin high with empty selection");

    AST_SEL_MAP: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        ((fault_sel_q | crit_sel_q) & ~`ALMF_STATUS_BITS) == 24'h000000)
        else $error("select holds unused bit");

    AST_FORCE_SET: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        hit(req_in, `ALMF_OFS_FORCE) && req_in.wdata[`ALMF_BIT_RELAY]
        |=> flags[`ALMF_BIT_RELAY])
        else $error("force did not set flag");

    AST_CLEAR_FLAG: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        hit(req_in, `ALMF_OFS_CLEAR) && req_in.wdata[6] && !set_vec[6]
        |=> !flags[6])
        else $error("clear did not clear flag");

    AST_ZCROSS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (interval_done_in && !set_vec[`ALMF_BIT_ZCROSS])
        |=> !flags[`ALMF_BIT_ZCROSS])
        else $error("zero crossing flag not self cleared");

    AST_FORCE_WINS: assert property (
        @(posedge clk_sys_in) disable iff (!rstn_in)
        (interval_done_in && hit(req_in, `ALMF_OFS_FORCE)
         && req_in.wdata[5]) |=> flags[5])
        else $error("interval clear beat force");
endmodule

// file: tb/almf_host_model.sv
// Host processor model issuing register requests
`timescale 1ns/100ps
module almf_host_model
    import almf_pkg::*;
(
    // Clock
    input wire logic clk_sys_in,
    // Register port
    input wire almf_word_t rdata_in,
    input wire logic rvalid_in,
    output almf_req_s req_out
);
    initial begin
        req_out = '0;
    end
    // register writes, including relay forcing
    // Forced words may carry the relay bit 2 or any test pattern
    task automatic wr(input logic [7:0] a, input almf_word_t d);
        @(posedge clk_sys_in) #1;
        req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_in) #1;
        // Released fields invert so a stale word never looks valid
        req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output almf_word_t d,
                      output bit ok);
        int i;
        ok = 1'b0;
        d = '0;
        @(posedge clk_sys_in) #1;
        req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req_out.wdata};
        @(posedge clk_sys_in) #1;
        req_out.rd = 1'b0;
        for (i = 0; i < 4 && !ok; i++) begin
            if (rvalid_in === 1'b1) begin
                d = rdata_in;
                ok = 1'b1;
            end else @(posedge clk_sys_in) #1;
        end
    endtask
endmodule

// file: tb/alarm_latch_mask_force_tb.sv
// Self-checking bench for the alarm latch, mask and force block
`timescale 1ns/100ps
`include "almf_regs.svh"
module alarm_latch_mask_force_tb
    import almf_pkg::*;
();
    logic clk_sys_in;
    logic rstn_in;
    almf_req_s req;
    almf_word_t rdata;
    logic rvalid;
    logic [23:0] alarm_event;
    logic interval_done;
    logic nvm_save;
    logic nvm_load;
    almf_nvm_s img_in;
    almf_nvm_s img_out;
    logic nvm_write;
    logic fault_pin;
    logic crit_pin;
    almf_word_t status;
    int mismatches = 0;
    int n_checks = 0;
    almf_top #(.WIDTH(24)) u_dut (.clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata),
        .rvalid_out(rvalid), .alarm_event_in(alarm_event),
        .interval_done_in(interval_done), .nvm_save_in(nvm_save),
        .nvm_load_in(nvm_load), .nvm_image_in(img_in),
        .nvm_image_out(img_out), .nvm_write_out(nvm_write),
        .fault_alarm_pin_out(fault_pin),
        .critical_alarm_pin_out(crit_pin), .alarm_status_out(status));
    almf_host_model u_host (.clk_sys_in(clk_sys_in), .rdata_in(rdata),
        .rvalid_in(rvalid), .req_out(req));
    initial begin
        clk_sys_in = 1'b0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end
    // ****************************************
    // Checking tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input almf_word_t seen, input almf_word_t exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input almf_word_t exp);
        almf_word_t d;
        bit ok;
        u_host.rd(a, d, ok);
        if (!ok) begin
            mismatches++;
            complete_run();
        end
        check(d, exp);
    endtask
    // Pins are registered, so look one edge after the flag moves
    task automatic pins(input logic f, input logic c);
        @(posedge clk_sys_in) #1;
        check({22'h0, fault_pin, crit_pin}, {22'h0, f, c});
    endtask
    task automatic tick(input logic [1:0] sel);
        @(posedge clk_sys_in) #1;
        interval_done = sel[0];
        nvm_save = sel[1];
        @(posedge clk_sys_in) #1;
        interval_done = 1'b0;
        nvm_save = 1'b0;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        int i;
        rstn_in = 1'b0;
        alarm_event = '0;
        interval_done = 1'b0;
        nvm_save = 1'b0;
        nvm_load = 1'b0;
        img_in = '0;
        repeat (5) @(posedge clk_sys_in);
        #1 rstn_in = 1'b1;
        rd_chk(`ALMF_OFS_FAULT_SEL, 24'h000000);
        rd_chk(`ALMF_OFS_CRIT_SEL, 24'h000000);
        rd_chk(`ALMF_OFS_LATCH, 24'h000000);
        rd_chk(`ALMF_OFS_FORCE, 24'h000000);
        rd_chk(8'h00, 24'h000000);
        u_host.wr(`ALMF_OFS_LATCH, 24'hFFFFFF);
        rd_chk(`ALMF_OFS_LATCH, 24'h6C0FF8);
        u_host.wr(`ALMF_OFS_FAULT_SEL, 24'hFFFFFF);
        rd_chk(`ALMF_OFS_FAULT_SEL, 24'hEC0FFE);
        $display("test reset and bit maps done");
        u_host.wr(`ALMF_OFS_LATCH, 24'h000040);
        u_host.wr(`ALMF_OFS_FORCE, 24'hFFFFFF);
        check(status, 24'hEC0FFE);
        tick(2'b01);
        check(status, 24'h800044);
        u_host.wr(`ALMF_OFS_FORCE, 24'h000000);
        check(status, 24'h800044);
        u_host.wr(`ALMF_OFS_STATUS, 24'hFFFFFF);
        rd_chk(`ALMF_OFS_STATUS, 24'h800044);
        u_host.wr(`ALMF_OFS_CLEAR, 24'h000040);
        check(status, 24'h800004);
        rd_chk(`ALMF_OFS_CLEAR, 24'h000000);
        u_host.wr(`ALMF_OFS_CLEAR, 24'h800004);
        check(status, 24'h000000);
        $display("test latch and clear done");
        u_host.wr(`ALMF_OFS_FAULT_SEL, 24'h000440);
        u_host.wr(`ALMF_OFS_CRIT_SEL, 24'h000004);
        u_host.wr(`ALMF_OFS_FORCE, 24'h000040);
        pins(1'b1, 1'b0);
        u_host.wr(`ALMF_OFS_FORCE, 24'h000004);
        pins(1'b1, 1'b1);
        u_host.wr(`ALMF_OFS_CLEAR, 24'h000044);
        u_host.wr(`ALMF_OFS_FORCE, 24'h000008);
        pins(1'b0, 1'b0);
        u_host.wr(`ALMF_OFS_CLEAR, 24'h000008);
        $display("test pins done");
        @(posedge clk_sys_in) #1 alarm_event = 24'h001020;
        @(posedge clk_sys_in) #1 alarm_event = '0;
        check(status, 24'h000020);
        tick(2'b01);
        check(status, 24'h000000);
        fork
            u_host.wr(`ALMF_OFS_FORCE, 24'h000020);
            tick(2'b01);
        join
        check(status, 24'h000020);
        $display("test events done");
        tick(2'b10);
        for (i = 0; i < 4 && nvm_write !== 1'b1; i++) @(posedge clk_sys_in) #1;
        check({23'h0, nvm_write}, 24'h000001);
        check(img_out.latch_cfg, 24'h000040);
        check(img_out.crit_sel, 24'h000004);
        check(img_out.fault_sel, 24'h000440);
        img_in = '{latch_cfg: 24'h000008, fault_sel: 24'h000010,
                   crit_sel: 24'h800000};
        @(posedge clk_sys_in) #1 nvm_load = 1'b1;
        @(posedge clk_sys_in) #1 nvm_load = 1'b0;
        rd_chk(`ALMF_OFS_LATCH, 24'h000008);
        rd_chk(`ALMF_OFS_FAULT_SEL, 24'h000010);
        $display("test store done");
        // A reset in mid-run must drop flags, pins and loaded selects
        u_host.wr(`ALMF_OFS_FORCE, 24'h000010);
        pins(1'b1, 1'b0);
        @(posedge clk_sys_in) #1 rstn_in = 1'b0;
        repeat (2) @(posedge clk_sys_in);
        #1 rstn_in = 1'b1;
        check(status, 24'h000000);
        pins(1'b0, 1'b0);
        rd_chk(`ALMF_OFS_FAULT_SEL, 24'h000000);
        rd_chk(`ALMF_OFS_LATCH, 24'h000000);
        $display("test reset in run done");
        complete_run();
    end
endmodule
